// File: design/media_bus_pkg.sv
// constants and types shared by the media serial bus port
`default_nettype none
package media_bus_pkg;
    // ------------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------------
    localparam int WORD_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam int BIT_CNT_W = 3;
    // ------------------------------------------------------------------
    // reset and end values
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
    localparam logic [1:0] COUNT_RST = 2'h0;
    localparam logic [1:0] COUNT_FULL = 2'h2;
    // ------------------------------------------------------------------
    // link state machine, gray along idle -> shift -> done
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LINK_IDLE = 2'h0,
        LINK_SHIFT = 2'h1,
        LINK_DONE = 2'h3
    } link_state_t;
endpackage : media_bus_pkg
`default_nettype wire

// File: design/media_serial_bus_port.sv
// device end of the media serial bus port, three- or five-pin wiring
`default_nettype none
// What this block does
// [R01] controller supplies bus clock, link runs on it
// [R02] transmitter drives shared data, others only receive
// [R03] five-pin mode: never drive shared data line
// [R04] signal line carries command bytes from device
// [R05] five-pin mode: never drive shared signal line
// [R06] data-out pin driven only in five-pin mode
// [R07] signal-out pin driven only in five-pin mode
// [R08] three-pin idle or reset: shared lines released
module media_serial_bus_port
    import media_bus_pkg::*;
(
    // system clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // configuration, system domain level
    input wire logic five_pin_mode_in,
    // transmit stream, system domain
    input wire logic [WORD_W-1:0] tx_data_in,
    input wire logic [WORD_W-1:0] tx_cmd_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    // line levels seen, system domain
    output logic rx_data_level_out,
    output logic rx_signal_level_out,
    // link clock from the bus controller
    input wire logic media_bus_clock_in,
    // shared data line
    input wire logic media_bus_shared_data_in,
    output logic media_bus_shared_data_out,
    output logic media_bus_shared_data_oe_out,
    // shared signal line
    input wire logic media_bus_shared_signal_in,
    output logic media_bus_shared_signal_out,
    output logic media_bus_shared_signal_oe_out,
    // dedicated five-pin outputs
    output logic media_bus_data_out,
    output logic media_bus_data_oe_out,
    output logic media_bus_signal_out,
    output logic media_bus_signal_oe_out
);
    // ------------------------------------------------------------------
    // two-entry buffer, system domain
    // ------------------------------------------------------------------
    logic [2*WORD_W-1:0] buf_mem_r [BUF_DEPTH];
    logic [2*WORD_W-1:0] buf_mem_nxt [BUF_DEPTH];
    logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [1:0] count_r, count_nxt;
    logic req_tgl_r, req_tgl_nxt, pending_r, pending_nxt;
    logic ack_s1_r, ack_s2_r, ack_seen_r;
    logic lvl_d_s1_r, lvl_d_s2_r, lvl_s_s1_r, lvl_s_s2_r;
    logic ack_tgl_r;
    logic push, pop;

    assign tx_ready_out = (count_r != COUNT_FULL);
    assign push = tx_valid_in && tx_ready_out;
    // a word leaves only once the link has shifted it out
    assign pop = pending_r && (ack_s2_r != ack_seen_r);

    always_comb begin
        buf_mem_nxt = buf_mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        req_tgl_nxt = req_tgl_r;
        pending_nxt = pending_r;
        if (push) begin
            buf_mem_nxt[wr_ptr_r] = {tx_cmd_in, tx_data_in};
            wr_ptr_nxt = ~wr_ptr_r;
        end
        if (pop) begin
            rd_ptr_nxt = ~rd_ptr_r;
            pending_nxt = 1'b0;
        end
        count_nxt = count_r + {1'b0, push} - {1'b0, pop};
        // head stays put while offered, so the link may read it late
        if (!pending_r && count_r != COUNT_RST) begin
            req_tgl_nxt = ~req_tgl_r;
            pending_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        buf_mem_r <= buf_mem_nxt;
        if (!rst_n_in) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= COUNT_RST;
            req_tgl_r <= 1'b0;
            pending_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_seen_r <= 1'b0;
            lvl_d_s1_r <= 1'b0;
            lvl_d_s2_r <= 1'b0;
            lvl_s_s1_r <= 1'b0;
            lvl_s_s2_r <= 1'b0;
            rx_data_level_out <= 1'b0;
            rx_signal_level_out <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            req_tgl_r <= req_tgl_nxt;
            pending_r <= pending_nxt;
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_seen_r <= ack_s2_r;
            lvl_d_s1_r <= media_bus_shared_data_in;
            lvl_d_s2_r <= lvl_d_s1_r;
            lvl_s_s1_r <= media_bus_shared_signal_in;
            lvl_s_s2_r <= lvl_s_s1_r;
            rx_data_level_out <= lvl_d_s2_r;
            rx_signal_level_out <= lvl_s_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // link domain, clocked by the controller's bus clock
    // ------------------------------------------------------------------
    logic lrst_s1_r, lrst_s2_r;
    logic req_s1_r, req_s2_r, req_seen_r;
    logic mode_s1_r, mode_s2_r;
    link_state_t state_r, state_nxt;
    logic [BIT_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [WORD_W-1:0] dsh_r, dsh_nxt, ssh_r, ssh_nxt;
    logic five_r, five_nxt, ack_tgl_nxt;
    logic req_seen_nxt;
    logic [2*WORD_W-1:0] head;

    assign head = buf_mem_r[rd_ptr_r];

    // reset reaches the link domain through two flops; the bus clock
    // must run a few edges after reset for the lines to release
    always_ff @(posedge media_bus_clock_in) begin
        lrst_s1_r <= rst_n_in;
        lrst_s2_r <= lrst_s1_r;
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        dsh_nxt = dsh_r;
        ssh_nxt = ssh_r;
        five_nxt = five_r;
        ack_tgl_nxt = ack_tgl_r;
        // only an idle link consumes a request toggle
        req_seen_nxt = (state_r == LINK_IDLE) ? req_s2_r : req_seen_r;
        case (state_r)
            LINK_IDLE: begin
                if (req_s2_r != req_seen_r) begin
                    // mode is frozen per word so pins never swap mid-byte
                    five_nxt = mode_s2_r;
                    dsh_nxt = head[WORD_W-1:0];
                    ssh_nxt = head[2*WORD_W-1:WORD_W]; // R04
                    cnt_nxt = BIT_CNT_RST;
                    state_nxt = LINK_SHIFT;
                end
            end
            LINK_SHIFT: begin
                dsh_nxt = {dsh_r[WORD_W-2:0], 1'b0};
                ssh_nxt = {ssh_r[WORD_W-2:0], 1'b0};
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == BIT_CNT_LAST) begin
                    state_nxt = LINK_DONE;
                end
            end
            LINK_DONE: begin
                ack_tgl_nxt = ~ack_tgl_r;
                state_nxt = LINK_IDLE;
            end
            default: begin
                state_nxt = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge media_bus_clock_in) begin // R01
        if (!lrst_s2_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_seen_r <= 1'b0;
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            state_r <= LINK_IDLE;
            cnt_r <= BIT_CNT_RST;
            dsh_r <= WORD_RST;
            ssh_r <= WORD_RST;
            five_r <= 1'b0;
            ack_tgl_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_seen_r <= req_seen_nxt;
            mode_s1_r <= five_pin_mode_in;
            mode_s2_r <= mode_s1_r;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            dsh_r <= dsh_nxt;
            ssh_r <= ssh_nxt;
            five_r <= five_nxt;
            ack_tgl_r <= ack_tgl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    logic sending;
    assign sending = (state_r == LINK_SHIFT) && lrst_s2_r;

    assign media_bus_shared_data_out = dsh_r[WORD_W-1];
    assign media_bus_shared_signal_out = ssh_r[WORD_W-1];
    assign media_bus_data_out = dsh_r[WORD_W-1];
    assign media_bus_signal_out = ssh_r[WORD_W-1];
    assign media_bus_shared_data_oe_out = sending && !five_r; // R02 R03 R08
    assign media_bus_shared_signal_oe_out = sending && !five_r; // R05 R08
    assign media_bus_data_oe_out = sending && five_r; // R06
    assign media_bus_signal_oe_out = sending && five_r; // R07

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_five_data_quiet: assert property (@(posedge media_bus_clock_in) // R03
        disable iff (!lrst_s2_r)
        five_r |-> !media_bus_shared_data_oe_out)
        else $error("shared data driven in five-pin mode");
    a_five_sig_quiet: assert property (@(posedge media_bus_clock_in) // R05
        disable iff (!lrst_s2_r)
        five_r |-> !media_bus_shared_signal_oe_out)
        else $error("shared signal driven in five-pin mode");
    a_dout_five_only: assert property (@(posedge media_bus_clock_in) // R06
        disable iff (!lrst_s2_r)
        media_bus_data_oe_out |-> five_r && !media_bus_shared_data_oe_out)
        else $error("data-out pin driven outside five-pin mode");
    a_sout_five_only: assert property (@(posedge media_bus_clock_in) // R07
        disable iff (!lrst_s2_r)
        media_bus_signal_oe_out |-> five_r)
        else $error("signal-out pin driven outside five-pin mode");
    a_byte_len: assert property (@(posedge media_bus_clock_in) // R02
        disable iff (!lrst_s2_r)
        $rose(sending) |-> sending [*8] ##1 !sending)
        else $error("byte drive not eight clocks long");
    a_idle_release: assert property (@(posedge media_bus_clock_in) // R08
        disable iff (!lrst_s2_r)
        (state_r != LINK_SHIFT) |-> !media_bus_shared_data_oe_out
            && !media_bus_shared_signal_oe_out)
        else $error("shared lines held while idle");
    a_reset_release: assert property (@(posedge media_bus_clock_in) // R08
        !lrst_s2_r |-> !media_bus_shared_data_oe_out
            && !media_bus_data_oe_out)
        else $error("line driven during reset");
    a_cmd_first_bit: assert property (@(posedge media_bus_clock_in) // R04
        disable iff (!lrst_s2_r)
        $rose(sending) |-> media_bus_signal_out
            == $past(head[2*WORD_W-1]))
        else $error("command byte not on signal line");
    a_buf_no_over: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        count_r == COUNT_FULL |-> !tx_ready_out ##1 count_r != 2'h3)
        else $error("buffer overrun");
endmodule : media_serial_bus_port
`default_nettype wire

// File: bench/bus_ctrl_model.sv
// bus controller model: line resolution and word collection
`default_nettype none
module bus_ctrl_model (
    // link clock and device pins
    input wire logic clk_in,
    input wire logic sd_in,
    input wire logic sd_oe_in,
    input wire logic ss_in,
    input wire logic ss_oe_in,
    input wire logic dd_in,
    input wire logic dd_oe_in,
    input wire logic ds_in,
    input wire logic ds_oe_in,
    // resolved shared lines and collected words
    output logic sd_level_out,
    output logic ss_level_out,
    output var logic [7:0] data_out,
    output var logic [7:0] cmd_out,
    output var logic five_out,
    output var logic bad_out,
    output var int cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic idle_r = 1'b0;
    logic [7:0] d_sh = 8'h00;
    logic [7:0] s_sh = 8'h00;
    int n = 0;
    logic bad_r = 1'b0;
    int cnt_r = 0;
    // a released line wobbles so a stale level cannot pass
    always @(posedge clk_in) idle_r <= ~idle_r;
    assign sd_level_out = sd_oe_in ? sd_in : idle_r;
    assign ss_level_out = ss_oe_in ? ss_in : ~idle_r;
    assign bad_out = bad_r;
    assign cnt_out = cnt_r;
    // bits change on the rising edge, taken on the falling one
    always @(negedge clk_in) begin
        if (sd_oe_in && dd_oe_in) bad_r <= 1'b1;
        if (sd_oe_in != ss_oe_in || dd_oe_in != ds_oe_in) bad_r <= 1'b1;
        if (!(sd_oe_in || dd_oe_in)) begin
            n = 0;
        end else begin
            d_sh = {d_sh[6:0], dd_oe_in ? dd_in : sd_in};
            s_sh = {s_sh[6:0], dd_oe_in ? ds_in : ss_in};
            n = n + 1;
            if (n == 8) begin
                n = 0;
                data_out <= d_sh;
                cmd_out <= s_sh;
                five_out <= dd_oe_in;
                cnt_r <= cnt_r + 1;
            end
        end
    end
endmodule : bus_ctrl_model
`default_nettype wire

// File: bench/tb.sv
// testbench: random words over both wirings, checked at the controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import media_bus_pkg::*;
    logic ref_clk_in = 1'b0;
    logic lclk = 1'b0;
    logic rst_n_in = 1'b0;
    logic five = 1'b0;
    logic [WORD_W-1:0] tdat = 8'h00;
    logic [WORD_W-1:0] tcmd = 8'h00;
    logic tval = 1'b0;
    logic trdy, sd_o, sd_oe, ss_o, ss_oe, dd_o, dd_oe, ds_o, ds_oe;
    logic sd_l, ss_l, m_five, m_bad;
    logic rx_dl, rx_sl;
    int dl_rises = 0;
    int sl_rises = 0;
    logic [7:0] m_d;
    logic [7:0] m_c;
    int m_cnt;
    int err_count = 0;
    int checked = 0;
    int stalls = 0;
    logic [15:0] lfsr_r = 16'h9db7;
    int exp_q[$];
    always #10 ref_clk_in = ~ref_clk_in;
    // link clock from the controller, free running
    always #6 lclk = ~lclk;
    media_serial_bus_port dut_u (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .five_pin_mode_in(five), .tx_data_in(tdat),
        .tx_cmd_in(tcmd), .tx_valid_in(tval), .tx_ready_out(trdy),
        .rx_data_level_out(rx_dl), .rx_signal_level_out(rx_sl),
        .media_bus_clock_in(lclk), .media_bus_shared_data_in(sd_l),
        .media_bus_shared_data_out(sd_o),
        .media_bus_shared_data_oe_out(sd_oe),
        .media_bus_shared_signal_in(ss_l),
        .media_bus_shared_signal_out(ss_o),
        .media_bus_shared_signal_oe_out(ss_oe),
        .media_bus_data_out(dd_o), .media_bus_data_oe_out(dd_oe),
        .media_bus_signal_out(ds_o), .media_bus_signal_oe_out(ds_oe));
    bus_ctrl_model ctrl_u (.clk_in(lclk), .sd_in(sd_o), .sd_oe_in(sd_oe),
        .ss_in(ss_o), .ss_oe_in(ss_oe), .dd_in(dd_o), .dd_oe_in(dd_oe),
        .ds_in(ds_o), .ds_oe_in(ds_oe), .sd_level_out(sd_l),
        .ss_level_out(ss_l), .data_out(m_d), .cmd_out(m_c),
        .five_out(m_five), .bad_out(m_bad), .cnt_out(m_cnt));
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_step
    task automatic fail(input string m);
        err_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // each collected word must be the oldest one offered, on its pair
    always @(m_cnt) begin
        #1;
        checked++;
        if (exp_q.size() == 0) begin
            fail("unexpected word");
        end else if ({m_five, m_c, m_d} !== exp_q.pop_front()) begin
            fail("word");
        end
    end
    // synced line levels must each rise at least once from the wobbling released lines
    always @(posedge rx_dl) dl_rises++;
    always @(posedge rx_sl) sl_rises++;
    task automatic check_idle();
        checked++;
        if ({sd_oe, ss_oe, dd_oe, ds_oe} !== 4'h0) fail("pin driven");
    endtask : check_idle
    // valid held until ready seen high at an edge
    task automatic send(input logic f);
        logic ok;
        lfsr_r = lfsr_step(lfsr_r);
        tdat = lfsr_r[7:0];
        tcmd = lfsr_r[15:8];
        tval = 1'b1;
        exp_q.push_back({f, lfsr_r[15:8], lfsr_r[7:0]});
        ok = 1'b0;
        for (int k = 0; k < 400 && !ok; k++) begin
            ok = (trdy === 1'b1);
            if (!ok) stalls++;
            @(posedge ref_clk_in);
            #2;
        end
        if (!ok) fail("ready timeout");
        if (!ok) tally_and_finish();
    endtask : send
    task automatic drain();
        tval = 1'b0;
        for (int k = 0; k < 2000 && exp_q.size() != 0; k++)
            @(posedge ref_clk_in);
        if (exp_q.size() != 0) fail("drain timeout");
        if (exp_q.size() != 0) tally_and_finish();
        repeat (10) @(posedge ref_clk_in);
        #2;
        check_idle();
    endtask : drain
    task automatic do_reset();
        rst_n_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #2;
        check_idle();
        checked++;
        if ({rx_dl, rx_sl} !== 2'h0) fail("levels not cleared");
        exp_q.delete();
        rst_n_in = 1'b1;
    endtask : do_reset
    initial begin
        do_reset();
        for (int m = 0; m < 2; m++) begin
            five = m[0];
            for (int i = 0; i < 6; i++) send(five);
            drain();
            $display("test wiring %0d done", m);
        end
        checked++;
        if (stalls == 0) fail("buffer never refused");
        send(five);
        tval = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #2;
        do_reset();
        send(1'b1);
        drain();
        $display("test mid-word reset done");
        checked++;
        if (m_bad !== 1'b0) fail("wrong pin pair");
        checked++;
        if (dl_rises == 0 || sl_rises == 0) fail("level stuck");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
